// ### sim/dtc_pin_model.sv
/*
 * far-side pin model: count pins, interrupt pins, external clock.
 * assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model
	import dtc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          ext_run,
	output var  dtc_pins_t     pins
);
	// ==========================================================
	// idle levels
	// irq one idles high: inactive for its active-low setting
	initial begin
		pins = 5'h16;
	end

	// ==========================================================
	// external clock, 20.6 ns period, stands still when unused
	always begin
		#10.3;
		if (ext_run) begin
			pins.ext_clock = ~pins.ext_clock;
		end else begin
			pins.ext_clock = 1'b0;
		end
	end

	// ==========================================================
	// pin events
	// each level held four clocks, well inside the sampling limit
	task automatic count_fall(input logic sel);
		@(posedge clk);
		if (sel) pins.timer_one_count_pin <= 1'b0;
		else pins.timer_zero_count_pin <= 1'b0;
		repeat (4) @(posedge clk);
		if (sel) pins.timer_one_count_pin <= 1'b1;
		else pins.timer_zero_count_pin <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic set_irq(input logic sel, input logic level);
		@(posedge clk);
		if (sel) pins.ext_irq_one_input <= level;
		else pins.ext_irq_zero_input <= level;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
/*
 * self-checking bench for the dual timer control block.
 * assumes dtc_pkg is compiled first and the pin model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dtc_pkg::*;
	logic         clk;
	logic         rst;
	logic         ext_run;
	logic         irq_zero_polarity;
	logic         irq_one_polarity;
	dtc_sfr_req_t sfr_req;
	dtc_ack_t     vector_ack;
	dtc_pins_t    pins;
	logic [7:0]   sfr_rdata;
	dtc_status_t  status;
	int           bad_count;
	int           check_count;

	dtc_timers dut (
		.clk               (clk),
		.rst               (rst),
		.sfr_req           (sfr_req),
		.vector_ack        (vector_ack),
		.pins              (pins),
		.irq_zero_polarity (irq_zero_polarity),
		.irq_one_polarity  (irq_one_polarity),
		.sfr_rdata         (sfr_rdata),
		.status            (status)
	);

	dtc_pin_model far (
		.clk     (clk),
		.ext_run (ext_run),
		.pins    (pins)
	);

	always #4 clk = ~clk;

	// ==========================================================
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			bad_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		sfr_req.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		sfr_req.rd <= 1'b0;
		@(negedge clk);
		check(sfr_rdata, exp);
	endtask

	task automatic stat(input logic [7:0] exp);
		@(negedge clk);
		check(status.timer_run_and_flag_control, exp);
	endtask

	task automatic ack(input logic [3:0] v);
		@(posedge clk);
		vector_ack <= v;
		@(posedge clk);
		vector_ack <= 4'h0;
	endtask

	// cycles between two overflow pulses of timer one, 0 if none
	task automatic measure(output int iv);
		int n;
		iv = 0;
		// let a tick from the previous setting drain first
		repeat (2) @(negedge clk);
		for (n = 0; n < 200 && status.t1_overflow !== 1'b1; n++) @(negedge clk);
		if (n < 200) begin
			@(negedge clk);
			for (iv = 1; iv < 200 && status.t1_overflow !== 1'b1; iv++)
				@(negedge clk);
		end
		if (iv >= 200) iv = 0;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] a;
		wr(8'h8F, 8'hFF);
		for (a = 8'h88; a <= 8'h8F; a++) rd_chk(a, 8'h00);
		stat(8'h00);
	endtask

	task automatic t_rw();
		logic [7:0] a;
		for (a = 8'h89; a <= 8'h8E; a++) wr(a, 8'hA5);
		for (a = 8'h89; a <= 8'h8E; a++) rd_chk(a, 8'hA5);
		check({4'h0, status.t23_clk_sel}, 8'h0A);
		wr(8'h8E, 8'h50);
		@(negedge clk);
		check({4'h0, status.t23_clk_sel}, 8'h05);
		for (a = 8'h89; a <= 8'h8E; a++) wr(a, 8'h00);
	endtask

	task automatic t_reload();
		wr(8'h89, 8'h06);
		wr(8'h8A, 8'hFE);
		wr(8'h8C, 8'h80);
		wr(8'h88, 8'h10);
		repeat (3) far.count_fall(1'b0);
		rd_chk(8'h8A, 8'h81);
		rd_chk(8'h8C, 8'h80);
		stat(8'h30);
		ack(4'b0100);
		stat(8'h10);
		wr(8'h88, 8'h00);
		far.count_fall(1'b0);
		rd_chk(8'h8A, 8'h81);
	endtask

	task automatic t_mode0();
		wr(8'h89, 8'h40);
		wr(8'h8D, 8'hFF);
		wr(8'h8B, 8'h1E);
		wr(8'h88, 8'h40);
		repeat (2) far.count_fall(1'b1);
		rd_chk(8'h8B, 8'h00);
		rd_chk(8'h8D, 8'h00);
		stat(8'hC0);
		ack(4'b1000);
		stat(8'h40);
		wr(8'h88, 8'h00);
	endtask

	task automatic t_gate();
		wr(8'h89, 8'h0D);
		wr(8'h8A, 8'h00);
		wr(8'h88, 8'h10);
		far.count_fall(1'b0);
		rd_chk(8'h8A, 8'h00);
		far.set_irq(1'b0, 1'b1);
		stat(8'h12);
		ack(4'b0001);
		stat(8'h12);
		far.count_fall(1'b0);
		rd_chk(8'h8A, 8'h01);
		far.set_irq(1'b0, 1'b0);
		wr(8'h88, 8'h00);
		stat(8'h00);
	endtask

	task automatic t_edge();
		wr(8'h88, 8'h04);
		far.set_irq(1'b1, 1'b0);
		stat(8'h0C);
		ack(4'b0010);
		stat(8'h04);
		repeat (4) @(posedge clk);
		stat(8'h04);
		wr(8'h88, 8'h00);
		repeat (2) @(posedge clk);
		stat(8'h08);
		far.set_irq(1'b1, 1'b1);
		wr(8'h88, 8'h00);
		stat(8'h00);
	endtask

	task automatic t_split();
		wr(8'h89, 8'h33);
		wr(8'h8E, 8'h04);
		wr(8'h8C, 8'hFE);
		repeat (10) @(posedge clk);
		stat(8'h00);
		wr(8'h88, 8'h40);
		repeat (6) @(posedge clk);
		stat(8'hC0);
		wr(8'h88, 8'h00);
		wr(8'h8E, 8'h00);
	endtask

	task automatic t_presc();
		logic [7:0] ck [5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h03};
		int ex [4] = '{12, 4, 48, 1};
		int iv;
		ext_run <= 1'b1;
		wr(8'h89, 8'h20);
		wr(8'h8B, 8'hFF);
		wr(8'h8D, 8'hFF);
		wr(8'h88, 8'h40);
		for (int i = 0; i < 4; i++) begin
			wr(8'h8E, ck[i]);
			measure(iv);
			check(iv[7:0], ex[i][7:0]);
			if (i == 0)
				check({7'h0, status.sys_div12_tick}, 8'h01);
		end
		wr(8'h8E, ck[4]);
		measure(iv);
		check({7'h0, status.ext_div8_tick}, 8'h01);
		// sampling the external clock adds one cycle of jitter each way
		check({7'h0, iv inside {[19:22]}}, 8'h01);
		wr(8'h89, 8'h30);
		measure(iv);
		check(iv[7:0], 8'h00);
		wr(8'h88, 8'h00);
		ext_run <= 1'b0;
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ext_run = 1'b0;
		irq_zero_polarity = 1'b1;
		irq_one_polarity = 1'b0;
		sfr_req = '0;
		vector_ack = '0;
		bad_count = 0;
		check_count = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rw();
		t_reload();
		t_mode0();
		t_gate();
		t_edge();
		t_split();
		t_presc();
		complete_run();
	end

	// the run needs under 1000 cycles; allow over thirty times that
	initial begin
		#300000;
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire

// ### src/dtc_cfg.svh
/*
 * constants for the dual timer control block: register addresses,
 * bit positions, reset value and prescale figures.
 * assumes it is included by bare name from the design file.
 */
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ==========================================================
// register addresses in special-function-register space
`define DTC_ADDR_TIMER_RUN_AND_FLAG_CONTROL     8'h88
`define DTC_ADDR_TIMER_MODE_SELECT     8'h89
`define DTC_ADDR_TL0      8'h8A
`define DTC_ADDR_TL1      8'h8B
`define DTC_ADDR_TH0      8'h8C
`define DTC_ADDR_TH1      8'h8D
`define DTC_ADDR_TIMER_CLOCK_SELECT    8'h8E
`define DTC_RESET_VAL     8'h00
`define DTC_UNMAPPED_VAL  8'h00

// ==========================================================
// control register bits
`define DTC_TF1           7
`define DTC_TR1           6
`define DTC_TF0           5
`define DTC_TR0           4
`define DTC_IE1           3
`define DTC_IT1           2
`define DTC_IE0           1
`define DTC_IT0           0

// ==========================================================
// mode register bits
`define DTC_TIMER_ONE_GATE         7
`define DTC_CT1           6
`define DTC_MODE1_HI      5
`define DTC_MODE1_LO      4
`define DTC_TIMER_ZERO_GATE         3
`define DTC_CT0           2
`define DTC_MODE0_HI      1
`define DTC_MODE0_LO      0

// ==========================================================
// clock select register bits
`define DTC_TIMER_THREE_HIGH_CLK_SEL          7
`define DTC_TIMER_TWO_LOW_CLK_SEL          4
`define DTC_T1M           3
`define DTC_T0M           2
`define DTC_SCA_HI        1
`define DTC_SCA_LO        0

// ==========================================================
// prescaler: one counter spans the longest divide
`define DTC_DIV_LONG      48
`define DTC_DIV_MID       12
`define DTC_DIV_SHORT     4
`define DTC_EXT_DIV       8
`define DTC_PRESC_LAST    6'h2F
`define DTC_EXT_LAST      3'h7

// ==========================================================
// positions in the pin sample vector
`define DTC_PIN_EXTCLK    0
`define DTC_PIN_T0        1
`define DTC_PIN_T1        2
`define DTC_PIN_EXT_IRQ_ZERO_INPUT      3
`define DTC_PIN_EXT_IRQ_ONE_INPUT      4

`endif

// ### src/dtc_pkg.sv
/*
 * types shared by the dual timer control block.
 * assumes the cpu drives the register port on the same clock.
 */
package dtc_pkg;

	// ==========================================================
	// register port from the cpu
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} dtc_sfr_req_t;

	// interrupt vector acknowledges, one-cycle pulses
	typedef struct packed {
		logic t1;
		logic t0;
		logic ie1;
		logic ie0;
	} dtc_ack_t;

	// external pins, asynchronous
	typedef struct packed {
		logic ext_irq_one_input;
		logic ext_irq_zero_input;
		logic timer_one_count_pin;
		logic timer_zero_count_pin;
		logic ext_clock;
	} dtc_pins_t;

	// status towards interrupt controller and other timers
	typedef struct packed {
		logic [7:0] timer_run_and_flag_control;
		logic [3:0] t23_clk_sel;
		logic       t1_overflow;
		logic       sys_div12_tick;
		logic       ext_div8_tick;
	} dtc_status_t;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'h0,
		DTC_MODE_16BIT  = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT  = 2'h3
	} dtc_mode_t;

	// ==========================================================
	// whole state of the block
	typedef struct packed {
		logic [7:0] timer_run_and_flag_control;
		logic [7:0] timer_mode_select;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [7:0] timer_clock_select;
		logic [5:0] presc_cnt;
		logic [2:0] ext_cnt;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] prev;
		logic [1:0] act_prev;
		logic [1:0] warm;
		logic [7:0] rdata;
		logic       t1_ovf;
		logic       div12_tick;
		logic       div8_tick;
	} dtc_state_t;

endpackage

// ### src/dtc_timers.sv
/*
 * control, flag and clock-select registers of two counter/timers,
 * with their counting bytes and the shared prescaler.
 * assumes a cpu on clk driving the register port, and asynchronous
 * count, interrupt and external clock pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dtc_cfg.svh"

// How it works
// [RULE1] timer one overflow sets its flag; software or vectoring clears it
// [RULE2] timer zero overflow sets its flag; software or vectoring clears it
// [RULE3] run bits 6 and 4 enable timer one and timer zero
// [RULE4] irq one flag set on selected edge or level; vector clears in edge mode
// [RULE5] level mode keeps each irq flag set while its input is active
// [RULE6] irq zero flag behaves like channel one under its own type bit
// [RULE7] type bits 2 and 0: zero level, one edge
// [RULE8] timer one gate makes it need run bit and active irq input
// [RULE9] timer zero gate makes it need run bit and active irq input
// [RULE10] timer one counts its clock, or falling pin edges in counter mode
// [RULE11] timer zero counts its clock, or falling pin edges in counter mode
// [RULE12] timer one modes: 13-bit, 16-bit, 8-bit reload, inactive
// [RULE13] timer zero modes: 13-bit, 16-bit, 8-bit reload, split bytes
// [RULE14] timer three high clock select only matters in split mode
// [RULE15] timer three low clock select picks external-select or system clock
// [RULE16] timer two high clock select only matters in split mode
// [RULE17] timer two low clock select picks external-select or system clock
// [RULE18] timer one clock select: prescaled or system, ignored as counter
// [RULE19] timer zero clock select: prescaled or system, ignored as counter
// [RULE20] prescale field gives sysclk/12, /4, /48 or external clock/8
// [RULE21] external clock/8 is synchronised; source must not exceed sysclk
// [RULE22] counting bytes are readable, writable and reset to zero
// [RULE23] 13-bit mode uses high byte and low five bits, flag on wrap
// [RULE24] reload mode counts low byte and reloads it from the high byte
// [RULE25] split mode high byte runs on timer one run bit, sets its flag
// [RULE26] external count source below quarter sysclk, two cycles per level
// [RULE27] pins synchronised; one falling edge gives exactly one event
module dtc_timers (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire dtc_pkg::dtc_sfr_req_t sfr_req,
	input  wire dtc_pkg::dtc_ack_t  vector_ack,
	input  wire dtc_pkg::dtc_pins_t pins,
	input  wire logic               irq_zero_polarity,
	input  wire logic               irq_one_polarity,
	output var  logic [7:0]         sfr_rdata,
	output var  dtc_pkg::dtc_status_t status
);
	import dtc_pkg::*;

	dtc_state_t s_reg;
	dtc_state_t s_next;

	// ==========================================================
	// decoded controls and events
	logic       wr_timer_run_and_flag_control, wr_timer_mode_select, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_timer_clock_select;
	logic       fall_t0, fall_t1, ext_rise;
	logic       act0, act1, edge0, edge1;
	logic       div4, div12, div48, ext8, presc_tick;
	logic       split;
	dtc_mode_t  mode0, mode1;
	logic       tick0, tick1, tickh, run0, run1;
	logic       inc0, inc1, inch, ovf0, ovf1, ovfh, set_tf1;

	assign wr_timer_run_and_flag_control  = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TIMER_RUN_AND_FLAG_CONTROL;
	assign wr_timer_mode_select  = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TIMER_MODE_SELECT;
	assign wr_tl0   = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TL0;
	assign wr_th0   = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TH0;
	assign wr_tl1   = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TL1;
	assign wr_th1   = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TH1;
	assign wr_timer_clock_select = sfr_req.wr && sfr_req.addr == `DTC_ADDR_TIMER_CLOCK_SELECT;

	// edges only from second-stage samples and their history
	assign fall_t0  = s_reg.prev[`DTC_PIN_T0]
		&& !s_reg.sync2[`DTC_PIN_T0];                     // [RULE27]
	assign fall_t1  = s_reg.prev[`DTC_PIN_T1]
		&& !s_reg.sync2[`DTC_PIN_T1];                     // [RULE27]
	assign ext_rise = !s_reg.prev[`DTC_PIN_EXTCLK]
		&& s_reg.sync2[`DTC_PIN_EXTCLK];                  // [RULE21]

	// polarity one means the input is active high; synchroniser zeros
	// after reset would look active for a low-active pin, so wait first
	assign act0  = s_reg.warm[1]
		&& s_reg.sync2[`DTC_PIN_EXT_IRQ_ZERO_INPUT] == irq_zero_polarity;   // [RULE5]
	assign act1  = s_reg.warm[1]
		&& s_reg.sync2[`DTC_PIN_EXT_IRQ_ONE_INPUT] == irq_one_polarity;    // [RULE5]
	assign edge0 = act0 && !s_reg.act_prev[0];                // [RULE27]
	assign edge1 = act1 && !s_reg.act_prev[1];                // [RULE27]

	// ==========================================================
	// prescaler: one mod-48 counter serves all three divides
	assign div4  = s_reg.presc_cnt[1:0] == 2'h3;
	assign div12 = s_reg.presc_cnt == 6'h0B || s_reg.presc_cnt == 6'h17
		|| s_reg.presc_cnt == 6'h23 || s_reg.presc_cnt == `DTC_PRESC_LAST;
	assign div48 = s_reg.presc_cnt == `DTC_PRESC_LAST;
	// ext clock must not beat sysclk, or rising edges are missed
	assign ext8  = ext_rise && s_reg.ext_cnt == `DTC_EXT_LAST; // [RULE21]

	always_comb begin
		case (s_reg.timer_clock_select[`DTC_SCA_HI:`DTC_SCA_LO])                // [RULE20]
			2'h0:    presc_tick = div12;
			2'h1:    presc_tick = div4;
			2'h2:    presc_tick = div48;
			default: presc_tick = ext8;
		endcase
	end

	// ==========================================================
	// clock choice, run gating and overflow detection
	assign mode0 = dtc_mode_t'(s_reg.timer_mode_select[`DTC_MODE0_HI:`DTC_MODE0_LO]);
	assign mode1 = dtc_mode_t'(s_reg.timer_mode_select[`DTC_MODE1_HI:`DTC_MODE1_LO]);
	assign split = mode0 == DTC_MODE_SPLIT;                        // [RULE13]

	assign tick0 = s_reg.timer_mode_select[`DTC_CT0] ? fall_t0                  // [RULE11]
		: (s_reg.timer_clock_select[`DTC_T0M] ? 1'b1 : presc_tick);             // [RULE19]
	// in split mode timer one loses its pin; clock select still applies
	assign tick1 = (s_reg.timer_mode_select[`DTC_CT1] && !split) ? fall_t1      // [RULE10]
		: (s_reg.timer_clock_select[`DTC_T1M] ? 1'b1 : presc_tick);             // [RULE18]
	assign tickh = s_reg.timer_clock_select[`DTC_T0M] ? 1'b1 : presc_tick;      // [RULE25]

	assign run0 = s_reg.timer_run_and_flag_control[`DTC_TR0]                             // [RULE3]
		&& (!s_reg.timer_mode_select[`DTC_TIMER_ZERO_GATE] || act0);                      // [RULE9]
	// split mode hands the run bit to the high byte of timer zero
	assign run1 = mode1 != DTC_MODE_SPLIT && (split ? 1'b1         // [RULE12]
		: s_reg.timer_run_and_flag_control[`DTC_TR1]                                     // [RULE3]
		&& (!s_reg.timer_mode_select[`DTC_TIMER_ONE_GATE] || act1));                     // [RULE8]

	assign inc0 = run0 && tick0;
	assign inc1 = run1 && tick1;
	assign inch = split && s_reg.timer_run_and_flag_control[`DTC_TR1] && tickh;          // [RULE25]

	always_comb begin
		case (mode0)
			DTC_MODE_13BIT:
				ovf0 = {s_reg.th0, s_reg.tl0[4:0]} == 13'h1FFF;     // [RULE23]
			DTC_MODE_16BIT:
				ovf0 = {s_reg.th0, s_reg.tl0} == 16'hFFFF;
			default:
				ovf0 = s_reg.tl0 == 8'hFF;
		endcase
		ovf0 = ovf0 && inc0;
		case (mode1)
			DTC_MODE_13BIT:
				ovf1 = {s_reg.th1, s_reg.tl1[4:0]} == 13'h1FFF;     // [RULE23]
			DTC_MODE_16BIT:
				ovf1 = {s_reg.th1, s_reg.tl1} == 16'hFFFF;
			default:
				ovf1 = s_reg.tl1 == 8'hFF;
		endcase
		ovf1 = ovf1 && inc1;
	end

	assign ovfh    = inch && s_reg.th0 == 8'hFF;
	assign set_tf1 = split ? ovfh : ovf1;                         // [RULE25]

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;

		// two stages before any logic looks at a pin
		s_next.sync1    = pins;                                   // [RULE27]
		s_next.sync2    = s_reg.sync1;
		s_next.prev     = s_reg.sync2;
		s_next.act_prev = {act1, act0};
		s_next.warm     = {s_reg.warm[0], 1'b1};

		s_next.presc_cnt = div48 ? 6'h00 : s_reg.presc_cnt + 6'h01;
		if (ext_rise)
			s_next.ext_cnt = s_reg.ext_cnt + 3'h1;                 // [RULE21]
		s_next.div12_tick = div12;
		s_next.div8_tick  = ext8;
		s_next.t1_ovf     = ovf1;

		// timer zero
		if (inc0) begin
			case (mode0)
				DTC_MODE_13BIT:
					{s_next.th0, s_next.tl0[4:0]} =
						{s_reg.th0, s_reg.tl0[4:0]} + 13'h0001;     // [RULE23]
				DTC_MODE_16BIT:
					{s_next.th0, s_next.tl0} =
						{s_reg.th0, s_reg.tl0} + 16'h0001;
				DTC_MODE_RELOAD:
					s_next.tl0 = (s_reg.tl0 == 8'hFF) ? s_reg.th0
						: s_reg.tl0 + 8'h01;                        // [RULE24]
				default:
					s_next.tl0 = s_reg.tl0 + 8'h01;                 // [RULE13]
			endcase
		end
		if (inch)
			s_next.th0 = s_reg.th0 + 8'h01;                        // [RULE25]

		// timer one
		if (inc1) begin
			case (mode1)
				DTC_MODE_13BIT:
					{s_next.th1, s_next.tl1[4:0]} =
						{s_reg.th1, s_reg.tl1[4:0]} + 13'h0001;     // [RULE23]
				DTC_MODE_16BIT:
					{s_next.th1, s_next.tl1} =
						{s_reg.th1, s_reg.tl1} + 16'h0001;
				default:
					s_next.tl1 = (s_reg.tl1 == 8'hFF) ? s_reg.th1
						: s_reg.tl1 + 8'h01;                        // [RULE24]
			endcase
		end

		// software writes win over counting in the same cycle
		if (wr_tl0)
			s_next.tl0 = sfr_req.wdata;                            // [RULE22]
		if (wr_th0)
			s_next.th0 = sfr_req.wdata;                            // [RULE22]
		if (wr_tl1)
			s_next.tl1 = sfr_req.wdata;                            // [RULE22]
		if (wr_th1)
			s_next.th1 = sfr_req.wdata;                            // [RULE22]
		if (wr_timer_mode_select)
			s_next.timer_mode_select = sfr_req.wdata;                           // [RULE12]
		// upper nibble feeds timers two and three outside
		if (wr_timer_clock_select)
			s_next.timer_clock_select = sfr_req.wdata;                          // [RULE17]

		// flags: write, then vector clear, then hardware set wins
		if (wr_timer_run_and_flag_control)
			s_next.timer_run_and_flag_control = sfr_req.wdata;                           // [RULE3]
		if (vector_ack.t1)
			s_next.timer_run_and_flag_control[`DTC_TF1] = 1'b0;                          // [RULE1]
		if (vector_ack.t0)
			s_next.timer_run_and_flag_control[`DTC_TF0] = 1'b0;                          // [RULE2]
		if (vector_ack.ie1 && s_reg.timer_run_and_flag_control[`DTC_IT1])
			s_next.timer_run_and_flag_control[`DTC_IE1] = 1'b0;                          // [RULE4]
		if (vector_ack.ie0 && s_reg.timer_run_and_flag_control[`DTC_IT0])
			s_next.timer_run_and_flag_control[`DTC_IE0] = 1'b0;                          // [RULE6]
		if (set_tf1)
			s_next.timer_run_and_flag_control[`DTC_TF1] = 1'b1;                          // [RULE1]
		if (ovf0)
			s_next.timer_run_and_flag_control[`DTC_TF0] = 1'b1;                          // [RULE2]
		// type bit one: edge; zero: level held while active
		if (s_reg.timer_run_and_flag_control[`DTC_IT1] ? edge1 : act1)                    // [RULE7]
			s_next.timer_run_and_flag_control[`DTC_IE1] = 1'b1;                          // [RULE5]
		if (s_reg.timer_run_and_flag_control[`DTC_IT0] ? edge0 : act0)                    // [RULE7]
			s_next.timer_run_and_flag_control[`DTC_IE0] = 1'b1;                          // [RULE6]

		// read data is registered; unmapped addresses read zero
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				`DTC_ADDR_TIMER_RUN_AND_FLAG_CONTROL:  s_next.rdata = s_reg.timer_run_and_flag_control;
				`DTC_ADDR_TIMER_MODE_SELECT:  s_next.rdata = s_reg.timer_mode_select;
				`DTC_ADDR_TL0:   s_next.rdata = s_reg.tl0;          // [RULE22]
				`DTC_ADDR_TL1:   s_next.rdata = s_reg.tl1;
				`DTC_ADDR_TH0:   s_next.rdata = s_reg.th0;
				`DTC_ADDR_TH1:   s_next.rdata = s_reg.th1;
				`DTC_ADDR_TIMER_CLOCK_SELECT: s_next.rdata = s_reg.timer_clock_select;
				default:         s_next.rdata = `DTC_UNMAPPED_VAL;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (rst)
			s_reg <= '0;                                           // [RULE22]
		else
			s_reg <= s_next;
	end

	assign sfr_rdata             = s_reg.rdata;
	assign status.timer_run_and_flag_control           = s_reg.timer_run_and_flag_control;
	// timers two and three apply the high selects only in their split mode
	assign status.t23_clk_sel    = s_reg.timer_clock_select[`DTC_TIMER_THREE_HIGH_CLK_SEL:`DTC_TIMER_TWO_LOW_CLK_SEL]; // [RULE14]
	assign status.t1_overflow    = s_reg.t1_ovf;
	assign status.sys_div12_tick = s_reg.div12_tick;              // [RULE15]
	assign status.ext_div8_tick  = s_reg.div8_tick;               // [RULE16]

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_tf0_set;
		ovf0 |=> s_reg.timer_run_and_flag_control[`DTC_TF0];
	endproperty
	a_tf0_set: assert property (p_tf0_set)                        // [RULE2]
		else $error("timer zero overflow did not set its flag");

	property p_tf1_set;
		(split ? ovfh : ovf1) |=> status.timer_run_and_flag_control[`DTC_TF1];
	endproperty
	a_tf1_set: assert property (p_tf1_set)                        // [RULE1]
		else $error("timer one flag not set on its overflow");

	property p_ack_clear;
		vector_ack.t0 && !ovf0 && !wr_timer_run_and_flag_control |=> !s_reg.timer_run_and_flag_control[`DTC_TF0];
	endproperty
	a_ack_clear: assert property (p_ack_clear)                    // [RULE2]
		else $error("vector did not clear timer zero flag");

	property p_stopped;
		!s_reg.timer_run_and_flag_control[`DTC_TR0] && !wr_tl0 |=> $stable(s_reg.tl0);
	endproperty
	a_stopped: assert property (p_stopped)                        // [RULE3]
		else $error("timer zero low byte moved while stopped");

	property p_gate;
		s_reg.timer_mode_select[`DTC_TIMER_ZERO_GATE] && !act0 && !wr_tl0 |=> $stable(s_reg.tl0);
	endproperty
	a_gate: assert property (p_gate)                              // [RULE9]
		else $error("gated timer zero counted with input inactive");

	property p_level;
		!s_reg.timer_run_and_flag_control[`DTC_IT1] && act1 |=> status.timer_run_and_flag_control[`DTC_IE1];
	endproperty
	a_level: assert property (p_level)                            // [RULE5]
		else $error("level irq one flag not set while active");

	sequence s_reload_ovf;
		mode0 == DTC_MODE_RELOAD && ovf0 && !wr_tl0 && !wr_th0;
	endsequence
	property p_reload;
		s_reload_ovf |=> s_reg.tl0 == $past(s_reg.th0)
			&& s_reg.th0 == $past(s_reg.th0);
	endproperty
	a_reload: assert property (p_reload)                          // [RULE24]
		else $error("reload mode did not reload low byte");

	property p_edge;
		s_reg.timer_run_and_flag_control[`DTC_IT0] && edge0 |=> status.timer_run_and_flag_control[`DTC_IE0];
	endproperty
	a_edge: assert property (p_edge)                              // [RULE6]
		else $error("edge on irq zero did not set flag");

	sequence s_div4_gap;
		!div4 [*3] ##1 div4;
	endsequence
	property p_div4;
		div4 |=> s_div4_gap;
	endproperty
	a_div4: assert property (p_div4)                              // [RULE20]
		else $error("divide-by-four tick spacing wrong");

	property p_pin_edge;
		s_reg.timer_mode_select[`DTC_CT0] && run0 && fall_t0 && mode0 == DTC_MODE_16BIT
			&& !wr_tl0 |=> s_reg.tl0 == $past(s_reg.tl0) + 8'h01;
	endproperty
	a_pin_edge: assert property (p_pin_edge)                      // [RULE11]
		else $error("pin falling edge did not count once");

endmodule
`default_nettype wire
